// [bit_branch_pkg.sv]
// Constants, opcodes and state encodings shared by the bit and branch execute block
//
// Operation
// [RQ1] Carry takes selected bit before modification
// [RQ2] Bit offset counts from operand LSB
// [RQ3] Test keeps, set, clear or invert bit
// [RQ4] Upward scan reports first set bit index
// [RQ5] Downward scan reports first set bit index
// [RQ6] Condition byte is 0 or 1 from flags
// [RQ7] Overflow variant writes overflow flag value
// [RQ8] Flag compare ANDs, sets sign zero parity
// [RQ9] Flag compare leaves both operands unchanged
// [RQ10] Flag compare clears carry and overflow
// [RQ11] Unconditional always taken, conditional on flags
// [RQ12] Jump saves no return address
// [RQ13] Relative target adds signed displacement
// [RQ14] Register target loads pointer, same segment
// [RQ15] Far target loads segment and offset
// [RQ16] Protected mode jump accepts gates, task segments
// [RQ17] Call pushes next address, then transfers
// [RQ18] Call targets: relative, near or far
// [RQ19] Return pops pointer into instruction pointer
// [RQ20] Return immediate is added to stack pointer
// [RQ21] Interrupt entry pushes flags with return pointer
// [RQ22] Interrupt return also restores flags
package bit_branch_pkg;

  // Register byte offsets on the APB bus
  localparam logic [7:0]  OFF_CTRL     = 8'h00;
  localparam logic [7:0]  OFF_OPA      = 8'h04;
  localparam logic [7:0]  OFF_OPB      = 8'h08;
  localparam logic [7:0]  OFF_RESULT   = 8'h0C;
  localparam logic [7:0]  OFF_FLAGS    = 8'h10;
  localparam logic [7:0]  OFF_IP       = 8'h14;
  localparam logic [7:0]  OFF_SP       = 8'h18;
  localparam logic [7:0]  OFF_CS       = 8'h1C;
  localparam logic [7:0]  OFF_STATUS   = 8'h20;

  // Control register fields
  localparam int          CTRL_OP_LSB  = 0;
  localparam int          CTRL_OP_W    = 5;
  localparam int          CTRL_CC_LSB  = 8;
  localparam int          CTRL_CC_W    = 4;
  localparam int          CTRL_PROT    = 12;

  // Flag bit positions inside flags_reg
  localparam int          FLAG_CF      = 0;
  localparam int          FLAG_PF      = 1;
  localparam int          FLAG_ZF      = 2;
  localparam int          FLAG_SF      = 3;
  localparam int          FLAG_OF      = 4;

  // Status register bit positions
  localparam int          STAT_BUSY    = 0;
  localparam int          STAT_TAKEN   = 1;
  localparam int          STAT_ILLEGAL = 2;

  // Reset values and stack step
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
  localparam logic [31:0] FLAGS_RESET  = 32'h0000_0000;
  localparam logic [31:0] IP_RESET     = 32'h0000_0000;
  localparam logic [31:0] CS_RESET     = 32'h0000_0000;
  localparam logic [31:0] WORD_BYTES   = 32'h0000_0004;
  localparam logic [15:0] SEL_MASK     = 16'hFFFF;

  // Operation codes written to the control register
  typedef enum logic [4:0] {
    OP_NOP          = 5'h00,
    OP_PROBE        = 5'h01,
    OP_PROBE_SET    = 5'h02,
    OP_PROBE_CLEAR  = 5'h03,
    OP_PROBE_INVERT = 5'h04,
    OP_SCAN_UP      = 5'h05,
    OP_SCAN_DOWN    = 5'h06,
    OP_COND_BYTE    = 5'h07,
    OP_FLAG_AND     = 5'h08,
    OP_JUMP_REL     = 5'h09,
    OP_JUMP_REG     = 5'h0A,
    OP_JUMP_FAR     = 5'h0B,
    OP_JUMP_GATE    = 5'h0C,
    OP_JUMP_COND    = 5'h0D,
    OP_CALL_REL     = 5'h0E,
    OP_CALL_REG     = 5'h0F,
    OP_CALL_FAR     = 5'h10,
    OP_RETURN       = 5'h11,
    OP_RETURN_IMM   = 5'h12,
    OP_IRQ_ENTRY    = 5'h13,
    OP_IRQ_RETURN   = 5'h14
  } op_t;

  // Sequencer states
  typedef enum logic [2:0] {
    S_IDLE    = 3'b000,
    S_EXEC    = 3'b001,
    S_PUSH_FL = 3'b010,
    S_PUSH_CS = 3'b011,
    S_PUSH_IP = 3'b100,
    S_POP_IP  = 3'b101,
    S_POP_CS  = 3'b110,
    S_POP_FL  = 3'b111
  } seq_t;

endpackage : bit_branch_pkg

// [bit_branch_exec.sv]
// Execute unit for single-bit, scan, condition-byte and control-transfer operations
`timescale 1ns/1ns
module bit_branch_exec #(
  parameter int STACK_DEPTH = 16
) (
  // Clock, reset and freeze
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Sequencer activity
  output logic             busy
);

  localparam int          IDX_W  = $clog2(STACK_DEPTH);
  // Empty stack sits one word above the top entry
  localparam logic [31:0] SP_TOP = 32'(STACK_DEPTH * 4);

  // Every piece of state in one record
  typedef struct packed {
    bit_branch_pkg::seq_t         state;    // Sequencer
    logic [31:0]                  ctrl;     // Operation and condition
    logic [31:0]                  opa;      // First operand
    logic [31:0]                  opb;      // Offset, displacement, selector
    logic [31:0]                  result;   // Last result
    logic [31:0]                  flags;    // flags_reg
    logic [31:0]                  ip;       // instr_pointer
    logic [31:0]                  sp;       // stack_pointer
    logic [31:0]                  cs;       // Code segment selector
    logic [31:0]                  tgt_ip;   // Pending call target offset
    logic [31:0]                  tgt_cs;   // Pending call target selector
    logic                         taken;    // Last transfer was taken
    logic                         illegal;  // Last operation refused
    logic                         rvalid;   // Read data captured, ready
    logic                         err;      // Captured slave error
    logic [31:0]                  rdata;    // Captured read data
    logic [STACK_DEPTH-1:0][31:0] stk;      // Stack memory
  } state_t;

  localparam state_t RESET_STATE = '{
    state:   bit_branch_pkg::S_IDLE,
    ctrl:    bit_branch_pkg::CTRL_RESET,
    flags:   bit_branch_pkg::FLAGS_RESET,
    ip:      bit_branch_pkg::IP_RESET,
    cs:      bit_branch_pkg::CS_RESET,
    sp:      SP_TOP,
    default: '0
  };

  state_t s_reg;    // Current state
  state_t s_next;   // Next state

  // Evaluate a four-bit condition code against the flags
  function automatic logic cond_eval(input logic [3:0] cc, input logic [31:0] f);
    logic c;
    logic z;
    logic s;
    logic o;
    logic p;
    logic r;
    c = f[bit_branch_pkg::FLAG_CF];
    z = f[bit_branch_pkg::FLAG_ZF];
    s = f[bit_branch_pkg::FLAG_SF];
    o = f[bit_branch_pkg::FLAG_OF];
    p = f[bit_branch_pkg::FLAG_PF];
    case (cc[3:1])
      3'h0:    r = o;             // Overflow
      3'h1:    r = c;             // Below
      3'h2:    r = z;             // Equal
      3'h3:    r = c | z;         // Below or equal
      3'h4:    r = s;             // Sign
      3'h5:    r = p;             // Parity
      3'h6:    r = s ^ o;         // Less
      3'h7:    r = (s ^ o) | z;   // Less or equal
      default: r = 1'b0;
    endcase
    // Odd codes are the negated forms
    return r ^ cc[0];
  endfunction : cond_eval

  // Decode whether an offset names a register
  function automatic logic addr_hit(input logic [7:0] a);
    case (a)
      bit_branch_pkg::OFF_CTRL, bit_branch_pkg::OFF_OPA, bit_branch_pkg::OFF_OPB,
      bit_branch_pkg::OFF_RESULT, bit_branch_pkg::OFF_FLAGS, bit_branch_pkg::OFF_IP,
      bit_branch_pkg::OFF_SP, bit_branch_pkg::OFF_CS, bit_branch_pkg::OFF_STATUS:
               return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : addr_hit

  // Lowest set bit index, searched upward from bit 0
  function automatic logic [4:0] scan_up(input logic [31:0] v);
    logic [4:0] idx;
    idx = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction : scan_up

  // Highest set bit index, searched downward from bit 31
  function automatic logic [4:0] scan_down(input logic [31:0] v);
    logic [4:0] idx;
    idx = 5'h00;
    for (int i = 0; i < 32; i++) begin
      if (v[i]) begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction : scan_down

  // Decoded control fields and datapath helpers
  bit_branch_pkg::op_t op;        // Current operation
  logic [3:0]          cc;        // Condition code
  logic                prot;      // Protected mode
  logic [4:0]          bit_idx;   // Selected bit offset
  logic                sel_bit;   // Selected bit value
  logic [31:0]         and_res;   // Flag-compare product
  logic [31:0]         sp_dec;    // Stack pointer after push
  logic [31:0]         sp_inc;    // Stack pointer after pop
  logic [IDX_W-1:0]    push_idx;  // Entry written by a push
  logic [IDX_W-1:0]    pop_idx;   // Entry read by a pop
  logic                acc_done;  // APB access completes this edge
  logic                wr_ok;     // Accepted write

  assign op       = bit_branch_pkg::op_t'(s_reg.ctrl[bit_branch_pkg::CTRL_OP_LSB +:
                                                     bit_branch_pkg::CTRL_OP_W]);
  assign cc       = s_reg.ctrl[bit_branch_pkg::CTRL_CC_LSB +: bit_branch_pkg::CTRL_CC_W];
  assign prot     = s_reg.ctrl[bit_branch_pkg::CTRL_PROT];
  assign bit_idx  = s_reg.opb[4:0];                             // [RQ2]
  assign sel_bit  = s_reg.opa[bit_idx];                         // [RQ2]
  assign and_res  = s_reg.opa & s_reg.opb;                      // [RQ8]
  assign sp_dec   = s_reg.sp - bit_branch_pkg::WORD_BYTES;
  assign sp_inc   = s_reg.sp + bit_branch_pkg::WORD_BYTES;
  assign push_idx = sp_dec[IDX_W+1:2];
  assign pop_idx  = s_reg.sp[IDX_W+1:2];
  assign acc_done = psel & penable & pready;
  assign wr_ok    = acc_done & pwrite & ~s_reg.err;

  // Handshake is combinational, data and error come from flip-flops
  assign pready  = ce & s_reg.rvalid;
  assign prdata  = s_reg.rdata;
  assign pslverr = s_reg.err;
  assign busy    = s_reg.state != bit_branch_pkg::S_IDLE;

  // Next-state logic for bus slave, registers and sequencer
  always_comb begin
    s_next = s_reg;

    // Capture read data and error one cycle ahead so the access needs no wait
    if (psel && !s_reg.rvalid) begin
      s_next.rvalid = 1'b1;
      s_next.err    = !addr_hit(paddr)
                    || (pwrite && (busy || paddr == bit_branch_pkg::OFF_RESULT
                                        || paddr == bit_branch_pkg::OFF_STATUS));
      case (paddr)
        bit_branch_pkg::OFF_CTRL:   s_next.rdata = s_reg.ctrl;
        bit_branch_pkg::OFF_OPA:    s_next.rdata = s_reg.opa;
        bit_branch_pkg::OFF_OPB:    s_next.rdata = s_reg.opb;
        bit_branch_pkg::OFF_RESULT: s_next.rdata = s_reg.result;
        bit_branch_pkg::OFF_FLAGS:  s_next.rdata = s_reg.flags;
        bit_branch_pkg::OFF_IP:     s_next.rdata = s_reg.ip;
        bit_branch_pkg::OFF_SP:     s_next.rdata = s_reg.sp;
        bit_branch_pkg::OFF_CS:     s_next.rdata = s_reg.cs;
        bit_branch_pkg::OFF_STATUS: begin
          s_next.rdata = '0;
          s_next.rdata[bit_branch_pkg::STAT_BUSY]    = busy;
          s_next.rdata[bit_branch_pkg::STAT_TAKEN]   = s_reg.taken;
          s_next.rdata[bit_branch_pkg::STAT_ILLEGAL] = s_reg.illegal;
        end
        default:                    s_next.rdata = '0;
      endcase
    end
    if (acc_done) begin
      s_next.rvalid = 1'b0;
    end

    // Register writes; only accepted while idle, so they never meet the sequencer
    if (wr_ok) begin
      case (paddr)
        bit_branch_pkg::OFF_CTRL: begin
          s_next.ctrl  = pwdata;
          s_next.state = bit_branch_pkg::S_EXEC;
        end
        bit_branch_pkg::OFF_OPA:   s_next.opa   = pwdata;
        bit_branch_pkg::OFF_OPB:   s_next.opb   = pwdata;
        bit_branch_pkg::OFF_FLAGS: s_next.flags = pwdata;
        bit_branch_pkg::OFF_IP:    s_next.ip    = pwdata;
        bit_branch_pkg::OFF_SP:    s_next.sp    = pwdata;
        bit_branch_pkg::OFF_CS:    s_next.cs    = pwdata;
        default:                   s_next.ctrl  = s_reg.ctrl;
      endcase
    end

    // Operation sequencer
    case (s_reg.state)
      bit_branch_pkg::S_IDLE: begin
        s_next.tgt_ip = s_reg.tgt_ip;
      end

      bit_branch_pkg::S_EXEC: begin
        s_next.state   = bit_branch_pkg::S_IDLE;
        s_next.taken   = 1'b0;
        s_next.illegal = 1'b0;
        case (op)
          bit_branch_pkg::OP_PROBE, bit_branch_pkg::OP_PROBE_SET,
          bit_branch_pkg::OP_PROBE_CLEAR, bit_branch_pkg::OP_PROBE_INVERT: begin
            // Old bit goes to carry; the write below uses that same old value
            s_next.flags[bit_branch_pkg::FLAG_CF] = sel_bit;                  // [RQ1]
            case (op)
              bit_branch_pkg::OP_PROBE_SET:    s_next.opa[bit_idx] = 1'b1;     // [RQ3]
              bit_branch_pkg::OP_PROBE_CLEAR:  s_next.opa[bit_idx] = 1'b0;     // [RQ3]
              bit_branch_pkg::OP_PROBE_INVERT: s_next.opa[bit_idx] = ~sel_bit; // [RQ3]
              default:                         s_next.opa[bit_idx] = sel_bit;  // [RQ3]
            endcase
            s_next.result = s_next.opa;
          end
          bit_branch_pkg::OP_SCAN_UP, bit_branch_pkg::OP_SCAN_DOWN: begin
            // A zero source leaves the destination alone and reports zero
            s_next.flags[bit_branch_pkg::FLAG_ZF] = s_reg.opa == '0;
            if (s_reg.opa != '0) begin
              if (op == bit_branch_pkg::OP_SCAN_UP) begin
                s_next.result = {27'h0000000, scan_up(s_reg.opa)};     // [RQ4]
              end else begin
                s_next.result = {27'h0000000, scan_down(s_reg.opa)};   // [RQ5]
              end
            end
          end
          bit_branch_pkg::OP_COND_BYTE: begin
            // Code zero is the overflow test
            s_next.result = {31'h00000000, cond_eval(cc, s_reg.flags)}; // [RQ6] [RQ7]
          end
          bit_branch_pkg::OP_FLAG_AND: begin
            // Product only feeds flags; operands and result stay as they were
            s_next.flags[bit_branch_pkg::FLAG_SF] = and_res[31];        // [RQ8] [RQ9]
            s_next.flags[bit_branch_pkg::FLAG_ZF] = and_res == '0;      // [RQ8]
            s_next.flags[bit_branch_pkg::FLAG_PF] = ~^and_res[7:0];     // [RQ8]
            s_next.flags[bit_branch_pkg::FLAG_CF] = 1'b0;               // [RQ10]
            s_next.flags[bit_branch_pkg::FLAG_OF] = 1'b0;               // [RQ10]
          end
          bit_branch_pkg::OP_JUMP_REL: begin
            s_next.ip    = s_reg.ip + s_reg.opb;                        // [RQ13] [RQ12]
            s_next.taken = 1'b1;                                        // [RQ11]
          end
          bit_branch_pkg::OP_JUMP_COND: begin
            if (cond_eval(cc, s_reg.flags)) begin                       // [RQ11]
              s_next.ip    = s_reg.ip + s_reg.opb;                      // [RQ13]
              s_next.taken = 1'b1;
            end
          end
          bit_branch_pkg::OP_JUMP_REG: begin
            s_next.ip    = s_reg.opa;                                   // [RQ14] [RQ12]
            s_next.taken = 1'b1;                                        // [RQ11]
          end
          bit_branch_pkg::OP_JUMP_FAR: begin
            s_next.ip    = s_reg.opa;                                   // [RQ15]
            s_next.cs    = {16'h0000, s_reg.opb[15:0] & bit_branch_pkg::SEL_MASK};
            s_next.taken = 1'b1;                                        // [RQ11]
          end
          bit_branch_pkg::OP_JUMP_GATE: begin
            // Gate and task targets resolve to a selector and offset
            if (prot) begin                                             // [RQ16]
              s_next.ip    = s_reg.opa;
              s_next.cs    = {16'h0000, s_reg.opb[15:0]};
              s_next.taken = 1'b1;
            end else begin
              s_next.illegal = 1'b1;
            end
          end
          bit_branch_pkg::OP_CALL_REL: begin
            s_next.tgt_ip = s_reg.ip + s_reg.opb;                       // [RQ18]
            s_next.tgt_cs = s_reg.cs;
            s_next.state  = bit_branch_pkg::S_PUSH_IP;                  // [RQ17]
          end
          bit_branch_pkg::OP_CALL_REG: begin
            s_next.tgt_ip = s_reg.opa;                                  // [RQ18]
            s_next.tgt_cs = s_reg.cs;
            s_next.state  = bit_branch_pkg::S_PUSH_IP;                  // [RQ17]
          end
          bit_branch_pkg::OP_CALL_FAR: begin
            s_next.tgt_ip = s_reg.opa;                                  // [RQ18]
            s_next.tgt_cs = {16'h0000, s_reg.opb[15:0]};
            s_next.state  = bit_branch_pkg::S_PUSH_CS;                  // [RQ17]
          end
          bit_branch_pkg::OP_IRQ_ENTRY: begin
            s_next.tgt_ip = s_reg.opa;
            s_next.tgt_cs = {16'h0000, s_reg.opb[15:0]};
            s_next.state  = bit_branch_pkg::S_PUSH_FL;                  // [RQ21]
          end
          bit_branch_pkg::OP_RETURN, bit_branch_pkg::OP_RETURN_IMM,
          bit_branch_pkg::OP_IRQ_RETURN: begin
            s_next.state = bit_branch_pkg::S_POP_IP;                    // [RQ19]
          end
          bit_branch_pkg::OP_NOP: begin
            s_next.taken = 1'b0;
          end
          default: begin
            s_next.illegal = 1'b1;
          end
        endcase
      end

      // Pushes walk the stack downward, one word per cycle
      bit_branch_pkg::S_PUSH_FL: begin
        s_next.stk[push_idx] = s_reg.flags;                             // [RQ21]
        s_next.sp            = sp_dec;
        s_next.state         = bit_branch_pkg::S_PUSH_CS;
      end
      bit_branch_pkg::S_PUSH_CS: begin
        s_next.stk[push_idx] = s_reg.cs;
        s_next.sp            = sp_dec;
        s_next.state         = bit_branch_pkg::S_PUSH_IP;
      end
      bit_branch_pkg::S_PUSH_IP: begin
        // Pointer already holds the following instruction's address
        s_next.stk[push_idx] = s_reg.ip;                                // [RQ17] [RQ21]
        s_next.sp            = sp_dec;
        s_next.ip            = s_reg.tgt_ip;                            // [RQ17]
        s_next.cs            = s_reg.tgt_cs;
        s_next.taken         = 1'b1;                                    // [RQ11]
        s_next.state         = bit_branch_pkg::S_IDLE;
      end

      // Pops walk back upward in the reverse order
      bit_branch_pkg::S_POP_IP: begin
        s_next.ip    = s_reg.stk[pop_idx];                              // [RQ19]
        s_next.taken = 1'b1;
        if (op == bit_branch_pkg::OP_RETURN_IMM) begin
          s_next.sp = sp_inc + s_reg.opb;                               // [RQ20]
        end else begin
          s_next.sp = sp_inc;
        end
        if (op == bit_branch_pkg::OP_IRQ_RETURN) begin
          s_next.state = bit_branch_pkg::S_POP_CS;                      // [RQ22]
        end else begin
          s_next.state = bit_branch_pkg::S_IDLE;
        end
      end
      bit_branch_pkg::S_POP_CS: begin
        s_next.cs    = s_reg.stk[pop_idx];
        s_next.sp    = sp_inc;
        s_next.state = bit_branch_pkg::S_POP_FL;
      end
      bit_branch_pkg::S_POP_FL: begin
        s_next.flags = s_reg.stk[pop_idx];                              // [RQ22]
        s_next.sp    = sp_inc;
        s_next.state = bit_branch_pkg::S_IDLE;
      end

      default: begin
        s_next.state = bit_branch_pkg::S_IDLE;
      end
    endcase
  end

  // State register; clock enable low freezes everything
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= RESET_STATE;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

endmodule : bit_branch_exec

// [bit_branch_exec_asserts.sv]
// Port-level checks on the execute unit's bus and sequencer
`timescale 1ns/1ns
module bit_branch_exec_asserts (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  // Bus
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Sequencer
  input wire logic        busy
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Accepted control write of one opcode while idle
  sequence ctrl_wr(logic [4:0] op);
    psel && penable && pready && pwrite && paddr == 8'h00 && pwdata[4:0] == op && !busy;
  endsequence
  // Enabled setup cycle to one address, then an enabled access cycle
  sequence setup_s(logic w, logic [7:0] a);
    psel && !penable && ce && pwrite == w && paddr == a ##1 psel && penable && ce;
  endsequence
  jump_no_push_a: assert property (ctrl_wr(5'h09) |=> busy ##1 !busy)
    else $error("jump held the sequencer too long");
  call_push_len_a: assert property (ctrl_wr(5'h0E) |=> busy [*2] ##1 !busy)
    else $error("near call did not take one push cycle");
  far_call_len_a: assert property (ctrl_wr(5'h10) |=> busy [*3] ##1 !busy)
    else $error("far call did not take two push cycles");
  return_pop_len_a: assert property (ctrl_wr(5'h11) |=> busy [*2] ##1 !busy)
    else $error("return did not take one pop cycle");
  irq_entry_len_a: assert property (ctrl_wr(5'h13) |=> busy [*4] ##1 !busy)
    else $error("interrupt entry did not take three push cycles");
  irq_return_len_a: assert property (ctrl_wr(5'h14) |=> busy [*4] ##1 !busy)
    else $error("interrupt return did not take three pop cycles");
  zero_wait_a: assert property ((psel && !penable && ce ##1 psel && penable && ce) |-> pready)
    else $error("access cycle had a wait state");
  result_ro_a: assert property (setup_s(1'b1, 8'h0C) |-> pslverr)
    else $error("write to result register accepted");
  status_busy_a: assert property (setup_s(1'b0, 8'h20) |-> prdata[0] == $past(busy))
    else $error("status busy bit differs from port");
endmodule : bit_branch_exec_asserts
bind bit_branch_exec bit_branch_exec_asserts i_chk (.pclk, .presetn, .ce, .paddr, .psel,
  .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .busy);

// [apb_host_model.sv]
// Bus master model issuing single-word transfers
`timescale 1ns/1ns
module apb_host_model (
  // Clock
  input  wire logic        pclk,
  // Request
  output logic      [7:0]  paddr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [31:0] pwdata,
  // Answer
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // Idle bus from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // Holds the request until pready is seen high at a rising edge or 50 edges pass, then takes the answer
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err, output logic to);
    int n;
    n = 0;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    to = (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d; // Stale data must not look valid
    @(posedge pclk);
  endtask : xfer
endmodule : apb_host_model

// [bit_branch_exec_tb.sv]
// Self-checking bench for the execute unit over its register bus
`timescale 1ns/1ns
module bit_branch_exec_tb;
  logic        pclk, presetn, ce;         // Clock, reset, enable
  logic [7:0]  paddr;                     // Bus request
  logic        psel, penable, pwrite;
  logic [31:0] pwdata, prdata, q, v;      // Bus data, last read, expected operand
  logic        pready, pslverr, busy, e, to;
  int          n_fail, num_checks;
  bit_branch_exec i_bit_branch_exec (.pclk, .presetn, .ce, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .busy);
  apb_host_model i_apb_host_model (.pclk, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr);
  // 25 MHz clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  // Condition value from OF,SF,ZF,PF,CF packed as bits 4..0
  function automatic logic cexp(input logic [4:0] f, input logic [3:0] c);
    logic [7:0] t;
    t = {(f[3] ^ f[4]) | f[2], f[3] ^ f[4], f[1], f[3], f[0] | f[2], f[2], f[0], f[4]};
    return t[c[3:1]] ^ c[0];
  endfunction : cexp
  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    num_checks++;
    if (got !== ex) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  // A hung transfer ends the run at once
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    i_apb_host_model.xfer(w, a, d, q, e, to);
    if (to) begin
      n_fail++;
      report_and_stop();
    end
  endtask : acc
  task wr(input logic [7:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] ex);
    acc(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), ex, q);
  endtask : rd
  // Start an operation and wait, bounded, for the sequencer to go idle
  task op(input logic [31:0] c);
    int n;
    n = 0;
    wr(8'h00, c);
    do begin
      @(negedge pclk);
      n++;
    end while (busy !== 1'b0 && n < 20);
    if (busy !== 1'b0) begin
      n_fail++;
      report_and_stop();
    end
    @(posedge pclk);
  endtask : op
  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    n_fail = 0;
    num_checks = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h18, 32'h40);
    for (int k = 1; k <= 4; k++) begin
      for (int b = 3; b <= 4; b++) begin
        v = 32'hF0;
        wr(8'h04, v);
        wr(8'h08, 32'(b));
        op(32'(k));
        rd(8'h10, {31'h0, v[b]});
        if (k == 2) v[b] = 1'b1;
        if (k == 3) v[b] = 1'b0;
        if (k == 4) v[b] = ~v[b];
        rd(8'h04, v);
      end
    end
    wr(8'h04, 32'h0010_0100);
    op(32'h05);
    rd(8'h0C, 32'h08);
    op(32'h06);
    rd(8'h0C, 32'h14);
    $display("test bits done");
    for (int i = 0; i < 2; i++) begin
      wr(8'h10, i ? 32'h0E : 32'h10);
      for (int c = 0; c < 16; c++) begin
        op({20'h0, 4'(c), 8'h07});
        rd(8'h0C, {31'h0, cexp(i ? 5'h0E : 5'h10, 4'(c))});
      end
    end
    wr(8'h10, 32'h11);
    wr(8'h04, 32'h8000_0003);
    wr(8'h08, 32'h8000_0001);
    op(32'h08);
    rd(8'h10, 32'h08);
    rd(8'h04, 32'h8000_0003);
    rd(8'h08, 32'h8000_0001);
    $display("test flags done");
    wr(8'h14, 32'h100);
    wr(8'h08, 32'hFFFF_FFF0);
    op(32'h09);
    rd(8'h14, 32'hF0);
    rd(8'h18, 32'h40);
    wr(8'h04, 32'h2000);
    op(32'h0A);
    rd(8'h14, 32'h2000);
    rd(8'h1C, 32'h0);
    wr(8'h04, 32'h4000);
    wr(8'h08, 32'h55);
    op(32'h100C);
    rd(8'h1C, 32'h55);
    wr(8'h08, 32'h66);
    op(32'h0B);
    rd(8'h1C, 32'h66);
    op(32'h0C);
    rd(8'h20, 32'h4);
    wr(8'h10, 32'h04);
    wr(8'h14, 32'h100);
    wr(8'h08, 32'h10);
    op(32'h040D);
    op(32'h050D);
    rd(8'h14, 32'h110);
    wr(8'h18, 32'h20);
    wr(8'h14, 32'h100);
    wr(8'h08, 32'h20);
    op(32'h0E);
    rd(8'h18, 32'h1C);
    op(32'h11);
    rd(8'h14, 32'h100);
    wr(8'h04, 32'h3000);
    wr(8'h08, 32'h77);
    op(32'h10);
    rd(8'h18, 32'h18);
    wr(8'h08, 32'h08);
    op(32'h12);
    rd(8'h18, 32'h24);
    wr(8'h10, 32'h1F);
    wr(8'h04, 32'h5000);
    wr(8'h08, 32'h66);
    op(32'h13);
    rd(8'h18, 32'h18);
    wr(8'h10, 32'h0);
    op(32'h14);
    rd(8'h10, 32'h1F);
    rd(8'h1C, 32'h77);
    $display("test transfers done");
    wr(8'h0C, 32'h1);
    chk("result write error", 32'h1, {31'h0, e});
    rd(8'h24, 32'h0);
    chk("unmapped read error", 32'h1, {31'h0, e});
    ce <= 1'b0;
    fork
      acc(1'b0, 8'h14, 32'h0);
      begin
        repeat (3) @(posedge pclk);
        ce <= 1'b1;
      end
    join
    chk("stalled read", 32'h100, q);
    $display("test bus done");
    report_and_stop();
  end
endmodule : bit_branch_exec_tb
